// File: src/dumc_pkg.sv
// shared constants, types and decode functions of the mode configuration block
`default_nettype none
package dumc_pkg;
  localparam int unsigned BYTE_W = 8;
  // register index; byte address is four times the index
  localparam logic [3:0] IDX_MODE_A    = 4'h0;
  localparam logic [3:0] IDX_STAT_A    = 4'h1;
  localparam logic [3:0] IDX_CMD_A     = 4'h2;
  localparam logic [3:0] IDX_DATA_A    = 4'h3;
  localparam logic [3:0] IDX_AUX       = 4'h4;
  localparam logic [3:0] IDX_IRQ       = 4'h5;
  localparam logic [3:0] IDX_TMR_HI    = 4'h6;
  localparam logic [3:0] IDX_TMR_LO    = 4'h7;
  localparam logic [3:0] IDX_MODE_B    = 4'h8;
  localparam logic [3:0] IDX_STAT_B    = 4'h9;
  localparam logic [3:0] IDX_CMD_B     = 4'hA;
  localparam logic [3:0] IDX_DATA_B    = 4'hB;
  localparam logic [3:0] IDX_GP        = 4'hC;
  localparam logic [3:0] IDX_PIN       = 4'hD;
  localparam logic [3:0] IDX_START_SET = 4'hE;
  localparam logic [3:0] IDX_STOP_CLR  = 4'hF;
  // pointer commands, upper nibble of a command write
  localparam logic [3:0] CMD_PTR_ZERO = 4'hB;
  localparam logic [3:0] CMD_PTR_ONE  = 4'h1;
  // writable bits of mode register zero
  localparam logic [7:0] MR0_MASK_A = 8'hF7;
  localparam logic [7:0] MR0_MASK_B = 8'hF0;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] TC_WORD  = 16'h0000;
  localparam logic [15:0] ONE_WORD = 16'h0001;
  // field positions
  localparam int unsigned MR0_WDOG   = 7;
  localparam int unsigned MR0_RXTRIG = 6;
  localparam int unsigned MR0_TXTRIG = 4;
  localparam int unsigned MR0_EXT2   = 2;
  localparam int unsigned MR0_TEST   = 1;
  localparam int unsigned MR0_EXT1   = 0;
  localparam int unsigned MR1_RXRTS  = 7;
  localparam int unsigned MR1_RXTRIG = 6;
  localparam int unsigned MR1_ERRMD  = 5;
  localparam int unsigned MR1_PMODE  = 3;
  localparam int unsigned MR1_PTYPE  = 2;
  localparam int unsigned MR1_CLEN   = 0;
  localparam int unsigned MR2_LOOP   = 6;
  localparam int unsigned MR2_TXRTS  = 5;
  localparam int unsigned MR2_CTS    = 4;
  localparam int unsigned MR2_STOP   = 0;
  localparam int unsigned IRQ_TIMER  = 3;

  typedef enum logic [1:0] {PTR_ZERO, PTR_ONE, PTR_TWO} dumc_ptr_e;
  typedef enum logic [1:0] {PAR_WITH, PAR_FORCE, PAR_NONE, PAR_MULTI} dumc_par_e;
  typedef enum logic [1:0] {LOOP_NONE, LOOP_ECHO, LOOP_LOCAL, LOOP_REMOTE} dumc_loop_e;

  // empty locations that trigger the transmitter
  function automatic logic [4:0] dumc_tx_thr(input logic [1:0] code, input logic deep);
    case (code)
      2'b00:   dumc_tx_thr = deep ? 5'h10 : 5'h08;
      2'b01:   dumc_tx_thr = deep ? 5'h08 : 5'h04;
      2'b10:   dumc_tx_thr = deep ? 5'h0C : 5'h06;
      default: dumc_tx_thr = 5'h01;
    endcase
  endfunction

  // filled locations that trigger the receiver
  function automatic logic [4:0] dumc_rx_thr(input logic [1:0] code, input logic deep);
    case (code)
      2'b00:   dumc_rx_thr = 5'h01;
      2'b01:   dumc_rx_thr = deep ? 5'h06 : 5'h03;
      2'b10:   dumc_rx_thr = deep ? 5'h0C : 5'h06;
      default: dumc_rx_thr = deep ? 5'h10 : 5'h08;
    endcase
  endfunction

  // stop length in sixteenths of a bit; codes jump from 1.000 to 1.563
  function automatic logic [5:0] dumc_stop_len(input logic [3:0] code);
    dumc_stop_len = code[3] ? {2'h0, code} + 6'h11 : {2'h0, code} + 6'h09;
  endfunction
endpackage
`default_nettype wire

// File: src/dumc_mode_chan.sv
// one channel's three mode registers behind the auto-advancing pointer
`default_nettype none
module dumc_mode_chan
  import dumc_pkg::*;
#(
  parameter logic [7:0] MR0_MASK = MR0_MASK_A,
  parameter logic       DEEP     = 1'b0
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       access,
  input  wire logic       write,
  input  wire logic [7:0] wdata,
  input  wire logic       ptrToZero,
  input  wire logic       ptrToOne,
  output logic      [7:0] rdata,
  output logic      [7:0] modeZero,
  output logic      [4:0] txThreshold,
  output logic      [4:0] rxThreshold,
  output logic      [3:0] dataBits,
  output logic            parityOdd,
  output logic            addrTag,
  output logic      [1:0] parityMode,
  output logic            blockErr,
  output logic            watchdogEn,
  output logic      [5:0] stopLen,
  output logic            ctsEn,
  output logic            txRtsEn,
  output logic            rxRtsEn,
  output logic      [1:0] loopMode
);
  typedef struct packed {
    dumc_ptr_e  ptr;
    logic [7:0] mr0;
    logic [7:0] mr1;
    logic [7:0] mr2;
  } dumc_chan_s;
  localparam dumc_chan_s CHAN_RST = '{ptr: PTR_ONE, mr0: RST_BYTE, mr1: RST_BYTE, mr2: RST_BYTE};

  dumc_chan_s st_reg;
  dumc_chan_s st_next;

  always_comb begin
    st_next = st_reg;
    if (ptrToZero) begin
      st_next.ptr = PTR_ZERO;
    end else if (ptrToOne) begin
      st_next.ptr = PTR_ONE;
    end else if (access) begin
      case (st_reg.ptr)
        PTR_ZERO: begin
          if (write) st_next.mr0 = wdata & MR0_MASK;
          st_next.ptr = PTR_ONE;
        end
        PTR_ONE: begin
          if (write) st_next.mr1 = wdata;
          st_next.ptr = PTR_TWO;
        end
        PTR_TWO: begin
          if (write) st_next.mr2 = wdata;
        end
        default: st_next.ptr = PTR_ONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) st_reg <= CHAN_RST;
    else st_reg <= st_next;
  end

  always_comb begin
    case (st_reg.ptr)
      PTR_ZERO: rdata = st_reg.mr0;
      PTR_ONE:  rdata = st_reg.mr1;
      default:  rdata = st_reg.mr2;
    endcase
  end

  assign modeZero    = st_reg.mr0;
  assign txThreshold = dumc_tx_thr(st_reg.mr0[MR0_TXTRIG +: 2], DEEP);
  assign rxThreshold = dumc_rx_thr({st_reg.mr0[MR0_RXTRIG], st_reg.mr1[MR1_RXTRIG]}, DEEP);
  assign watchdogEn  = st_reg.mr0[MR0_WDOG];
  assign dataBits    = {2'h0, st_reg.mr1[MR1_CLEN +: 2]} + 4'h5;
  assign parityMode  = st_reg.mr1[MR1_PMODE +: 2];
  assign parityOdd   = st_reg.mr1[MR1_PTYPE] & (parityMode != PAR_MULTI);
  assign addrTag     = st_reg.mr1[MR1_PTYPE] & (parityMode == PAR_MULTI);
  assign blockErr    = st_reg.mr1[MR1_ERRMD];
  assign rxRtsEn     = st_reg.mr1[MR1_RXRTS];
  assign stopLen     = dumc_stop_len(st_reg.mr2[MR2_STOP +: 4]);
  assign ctsEn       = st_reg.mr2[MR2_CTS];
  assign txRtsEn     = st_reg.mr2[MR2_TXRTS];
  assign loopMode    = st_reg.mr2[MR2_LOOP +: 2];

  a_ptr_after_reset: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> st_reg.ptr == PTR_ONE && st_reg.mr0 == RST_BYTE)
    else $error("pointer not at mode one after reset");
  a_ptr_zero_cmd: assert property (@(posedge ref_clk) disable iff (rst)
    ptrToZero |=> st_reg.ptr == PTR_ZERO)
    else $error("pointer command zero not taken");
  a_mode_zero_step: assert property (@(posedge ref_clk) disable iff (rst)
    access && !ptrToZero && !ptrToOne && st_reg.ptr == PTR_ZERO |=> st_reg.ptr == PTR_ONE)
    else $error("pointer did not leave mode zero");
  a_mode_one_step: assert property (@(posedge ref_clk) disable iff (rst)
    access && !ptrToZero && !ptrToOne && st_reg.ptr == PTR_ONE |=> st_reg.ptr == PTR_TWO)
    else $error("pointer did not leave mode one");
  a_mode_two_hold: assert property (@(posedge ref_clk) disable iff (rst)
    access && write && !ptrToZero && !ptrToOne && st_reg.ptr == PTR_TWO
      |=> st_reg.ptr == PTR_TWO && st_reg.mr2 == $past(wdata))
    else $error("mode two access moved pointer or lost data");
  a_unused_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg.mr0 & ~MR0_MASK) == RST_BYTE)
    else $error("unused mode zero bit set");
endmodule
`default_nettype wire

// File: src/dumc_timer.sv
// counter/timer: preload, countdown, square output, ready flag
`default_nettype none
module dumc_timer
  import dumc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        preHiWr,
  input  wire logic        preLoWr,
  input  wire logic [7:0]  wdata,
  input  wire logic        startCmd,
  input  wire logic        stopCmd,
  output logic      [15:0] count,
  output logic             tOut,
  output logic             ready
);
  typedef struct packed {
    logic [15:0] preload;
    logic [15:0] cnt;
    logic        run;
    logic        out;
    logic        rdy;
  } dumc_tmr_s;
  localparam dumc_tmr_s TMR_RST = '{preload: RST_WORD, cnt: RST_WORD, run: 1'b0, out: 1'b0, rdy: 1'b0};

  dumc_tmr_s st_reg;
  dumc_tmr_s st_next;
  logic      riseEvt;

  always_comb begin
    st_next = st_reg;
    riseEvt = 1'b0;
    if (preHiWr) st_next.preload[15:8] = wdata;
    if (preLoWr) st_next.preload[7:0] = wdata;
    // a new preload only takes effect at terminal count or start
    if (startCmd) begin
      st_next.cnt = st_reg.preload;
      st_next.out = 1'b1;
      st_next.run = 1'b1;
    end else if (st_reg.run) begin
      if (st_reg.cnt == TC_WORD) begin
        st_next.cnt = st_reg.preload;
        st_next.out = ~st_reg.out;
        riseEvt     = ~st_reg.out;
      end else begin
        st_next.cnt = st_reg.cnt - ONE_WORD;
      end
    end
    // set wins over the clear from a stop read
    if (stopCmd) st_next.rdy = 1'b0;
    if (riseEvt) st_next.rdy = 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) st_reg <= TMR_RST;
    else st_reg <= st_next;
  end

  assign count = st_reg.cnt;
  assign tOut  = st_reg.out;
  assign ready = st_reg.rdy;

  a_stop_clears: assert property (@(posedge ref_clk) disable iff (rst)
    stopCmd && !riseEvt |=> !ready)
    else $error("stop read did not clear timer ready");
endmodule
`default_nettype wire

// File: src/dumc_top.sv
// dual channel mode configuration and shared registers, APB slave
//
// Overview of operation
// - command upper nibble B points to mode zero; access then moves to one
// - reset or command nibble 1 points to mode one; access moves to two
// - mode two accesses leave the pointer where it is
// - channel A mode zero bit 0 selects extended baud table one
// - channel A mode zero bit 2 selects extended baud table two
// - channel A mode zero bit 1 selects factory test mode
// - unused mode zero bits ignore writes and read zero
// - transmit trigger bits 5:4 pick 8, 4, 6 or 1 empty slots, or 16, 8, 12 or 1 on the deep part
// - deep part transmit trigger code 00 means 16 empty slots
// - receive trigger is mode zero bit 6 over mode one bit 6
// - mode zero bit 7 enables the receive watchdog, off at reset
// - mode one bits 1:0 give 5 to 8 data bits
// - outside multidrop mode one bit 2 picks even or odd parity
// - in multidrop mode one bit 2 tags address or data
// - mode one bits 4:3 pick with, forced, no parity or multidrop
// - mode one bit 5 picks character or block error reporting
// - mode one bit 7 drives the channel pin as receive RTS, low active
// - mode two bits 3:0 give stop length 0.563 to 2.000 bits
// - mode two bit 4 enables automatic CTS transmit control
// - mode two bit 5 drives the channel pin as transmit RTS
// - mode two bits 7:6 pick normal, echo, local or remote loop
//
// Local design decision: the APB slave port.
`default_nettype none
module dumc_top
  import dumc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter logic        DEEP   = 1'b0
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [6:0]        inPins,
  input  wire logic [6:0]        evtSrc,
  input  wire logic              rtsReqAN,
  input  wire logic              rtsReqBN,
  output logic      [7:0]        outPins,
  output logic      [7:0]        outPinConfig,
  output logic      [7:0]        auxControl,
  output logic                   irq,
  output logic                   timerOut,
  output logic                   baudExt1,
  output logic                   baudExt2,
  output logic                   testMode,
  output logic      [4:0]        txThrA,
  output logic      [4:0]        rxThrA,
  output logic      [3:0]        dataBitsA,
  output logic                   parityOddA,
  output logic                   addrTagA,
  output logic      [1:0]        parityModeA,
  output logic                   blockErrA,
  output logic                   watchdogEnA,
  output logic      [5:0]        stopLenA,
  output logic                   ctsEnA,
  output logic      [1:0]        loopModeA,
  output logic      [4:0]        txThrB,
  output logic      [4:0]        rxThrB,
  output logic      [3:0]        dataBitsB,
  output logic                   parityOddB,
  output logic                   addrTagB,
  output logic      [1:0]        parityModeB,
  output logic                   blockErrB,
  output logic                   watchdogEnB,
  output logic      [5:0]        stopLenB,
  output logic                   ctsEnB,
  output logic      [1:0]        loopModeB
);
  typedef struct packed {
    logic [7:0] auxiliary_control;
    logic [7:0] interrupt_mask;
    logic [7:0] general_purpose;
    logic [7:0] output_pin_config;
    logic [7:0] opr;
    logic [7:0] pins;
    logic [7:0] rdata;
    logic [6:0] inMeta;
    logic [6:0] inSync;
    logic       err;
    logic       irq;
  } dumc_top_s;
  localparam dumc_top_s TOP_RST = '{
    auxiliary_control: RST_BYTE, interrupt_mask: RST_BYTE, general_purpose: RST_BYTE, output_pin_config: RST_BYTE, opr: RST_BYTE,
    pins: RST_BYTE, rdata: RST_BYTE, inMeta: 7'h00, inSync: 7'h00, err: 1'b0, irq: 1'b0};

  dumc_top_s   st_reg;
  dumc_top_s   st_next;

  logic        setup;
  logic        access;
  logic [3:0]  idx;
  logic        inRange;
  logic        unmapped;
  logic        wrEn;
  logic        rdEn;
  logic [7:0]  wByte;
  logic        accA;
  logic        accB;
  logic        cmdA;
  logic        cmdB;
  logic [7:0]  rdataA;
  logic [7:0]  rdataB;
  logic [7:0]  modeZeroA;
  logic        txRtsA;
  logic        rxRtsA;
  logic        txRtsB;
  logic        rxRtsB;
  logic [15:0] tmrCount;
  logic        tmrReady;
  logic        tmrOut;
  logic [7:0]  interrupt_status;

  // bus decode; the slave never inserts wait states
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign idx      = paddr[5:2];
  assign inRange  = (paddr[ADDR_W-1:6] == '0);
  assign unmapped = ~inRange | (idx == IDX_STAT_A) | (idx == IDX_DATA_A) |
                    (idx == IDX_STAT_B) | (idx == IDX_DATA_B);
  assign wrEn     = access & pwrite & inRange;
  assign rdEn     = access & ~pwrite & inRange;
  assign wByte    = pwdata[7:0];

  // mode pointer strobes and pointer commands per channel
  assign accA = (wrEn | rdEn) & (idx == IDX_MODE_A);
  assign accB = (wrEn | rdEn) & (idx == IDX_MODE_B);
  assign cmdA = wrEn & (idx == IDX_CMD_A);
  assign cmdB = wrEn & (idx == IDX_CMD_B);

  // timer ready takes slot 3; external sources 6:3 move up one slot
  assign interrupt_status = {evtSrc[6:3], tmrReady, evtSrc[2:0]};

  always_comb begin
    st_next        = st_reg;
    st_next.inMeta = inPins;
    st_next.inSync = st_reg.inMeta;
    if (setup) begin
      st_next.err = unmapped;
      case (idx)
        IDX_MODE_A:    st_next.rdata = rdataA;
        IDX_MODE_B:    st_next.rdata = rdataB;
        IDX_IRQ:       st_next.rdata = interrupt_status;
        IDX_TMR_HI:    st_next.rdata = tmrCount[15:8];
        IDX_TMR_LO:    st_next.rdata = tmrCount[7:0];
        IDX_GP:        st_next.rdata = st_reg.general_purpose;
        IDX_PIN:       st_next.rdata = {1'b0, st_reg.inSync};
        default:       st_next.rdata = RST_BYTE;
      endcase
      if (!inRange) st_next.rdata = RST_BYTE;
    end
    if (wrEn) begin
      case (idx)
        IDX_AUX:       st_next.auxiliary_control = wByte;
        IDX_IRQ:       st_next.interrupt_mask = wByte;
        IDX_GP:        st_next.general_purpose = wByte;
        IDX_PIN:       st_next.output_pin_config = wByte;
        IDX_START_SET: st_next.opr = st_reg.opr | wByte;
        IDX_STOP_CLR:  st_next.opr = st_reg.opr & ~wByte;
        default:       st_next.err = st_reg.err;
      endcase
    end
    st_next.pins = st_next.opr;
    // either RTS control takes the pin over; both set is a software fault
    if (rxRtsA | txRtsA) st_next.pins[0] = rtsReqAN;
    if (rxRtsB | txRtsB) st_next.pins[1] = rtsReqBN;
    st_next.irq = |(interrupt_status & st_reg.interrupt_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) st_reg <= TOP_RST;
    else st_reg <= st_next;
  end

  dumc_mode_chan #(
    .MR0_MASK (MR0_MASK_A),
    .DEEP     (DEEP)
  ) u_chan_a (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .access      (accA),
    .write       (pwrite),
    .wdata       (wByte),
    .ptrToZero   (cmdA && wByte[7:4] == CMD_PTR_ZERO),
    .ptrToOne    (cmdA && wByte[7:4] == CMD_PTR_ONE),
    .rdata       (rdataA),
    .modeZero    (modeZeroA),
    .txThreshold (txThrA),
    .rxThreshold (rxThrA),
    .dataBits    (dataBitsA),
    .parityOdd   (parityOddA),
    .addrTag     (addrTagA),
    .parityMode  (parityModeA),
    .blockErr    (blockErrA),
    .watchdogEn  (watchdogEnA),
    .stopLen     (stopLenA),
    .ctsEn       (ctsEnA),
    .txRtsEn     (txRtsA),
    .rxRtsEn     (rxRtsA),
    .loopMode    (loopModeA)
  );

  dumc_mode_chan #(
    .MR0_MASK (MR0_MASK_B),
    .DEEP     (DEEP)
  ) u_chan_b (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .access      (accB),
    .write       (pwrite),
    .wdata       (wByte),
    .ptrToZero   (cmdB && wByte[7:4] == CMD_PTR_ZERO),
    .ptrToOne    (cmdB && wByte[7:4] == CMD_PTR_ONE),
    .rdata       (rdataB),
    .modeZero    (),
    .txThreshold (txThrB),
    .rxThreshold (rxThrB),
    .dataBits    (dataBitsB),
    .parityOdd   (parityOddB),
    .addrTag     (addrTagB),
    .parityMode  (parityModeB),
    .blockErr    (blockErrB),
    .watchdogEn  (watchdogEnB),
    .stopLen     (stopLenB),
    .ctsEn       (ctsEnB),
    .txRtsEn     (txRtsB),
    .rxRtsEn     (rxRtsB),
    .loopMode    (loopModeB)
  );

  // start and stop are read side effects only
  dumc_timer u_timer (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .preHiWr  (wrEn && idx == IDX_TMR_HI),
    .preLoWr  (wrEn && idx == IDX_TMR_LO),
    .wdata    (wByte),
    .startCmd (rdEn && idx == IDX_START_SET),
    .stopCmd  (rdEn && idx == IDX_STOP_CLR),
    .count    (tmrCount),
    .tOut     (tmrOut),
    .ready    (tmrReady)
  );

  assign prdata       = {24'h000000, st_reg.rdata};
  assign pready       = 1'b1;
  assign pslverr      = access & st_reg.err;
  assign outPins      = st_reg.pins;
  assign outPinConfig = st_reg.output_pin_config;
  assign auxControl   = st_reg.auxiliary_control;
  assign irq          = st_reg.irq;
  assign timerOut     = tmrOut;
  // baud table and test selects live in channel A only, shared by both
  assign baudExt1     = modeZeroA[MR0_EXT1];
  assign baudExt2     = modeZeroA[MR0_EXT2];
  assign testMode     = modeZeroA[MR0_TEST];

  // interrupt level
  a_irq_follows: assert property (@(posedge ref_clk) disable iff (rst)
    (interrupt_status & st_reg.interrupt_mask) != RST_BYTE |=> irq)
    else $error("masked status set but interrupt low");

  a_irq_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (interrupt_status & st_reg.interrupt_mask) == RST_BYTE |=> !irq)
    else $error("interrupt high with nothing enabled");

  // bus answer
  a_err_unmapped: assert property (@(posedge ref_clk) disable iff (rst)
    setup && unmapped ##1 access |-> pslverr && prdata[7:0] == RST_BYTE)
    else $error("unmapped access not refused");

  a_err_access_only: assert property (@(posedge ref_clk) disable iff (rst)
    !access |-> !pslverr)
    else $error("error flag outside access phase");

  // shared registers
  a_set_bits: assert property (@(posedge ref_clk) disable iff (rst)
    wrEn && idx == IDX_START_SET |=> (st_reg.opr & $past(wByte)) == $past(wByte))
    else $error("output set write lost a bit");

  a_clr_bits: assert property (@(posedge ref_clk) disable iff (rst)
    wrEn && idx == IDX_STOP_CLR |=> (st_reg.opr & $past(wByte)) == RST_BYTE)
    else $error("output clear write left a bit");

  a_gp_write: assert property (@(posedge ref_clk) disable iff (rst)
    wrEn && idx == IDX_GP |=> st_reg.general_purpose == $past(wByte))
    else $error("general register write lost");

  a_output_pin_config_write: assert property (@(posedge ref_clk) disable iff (rst)
    wrEn && idx == IDX_PIN |=> outPinConfig == $past(wByte))
    else $error("output config write lost");

  a_aux_write: assert property (@(posedge ref_clk) disable iff (rst)
    wrEn && idx == IDX_AUX |=> auxControl == $past(wByte))
    else $error("aux control write lost");

  // pin override and mode registers
  a_rts_pin: assert property (@(posedge ref_clk) disable iff (rst)
    rxRtsA && $stable(rxRtsA) ##1 $stable(rtsReqAN) |-> outPins[0] == $past(rtsReqAN))
    else $error("receive RTS not on channel A pin");

  a_rts_tx_pin: assert property (@(posedge ref_clk) disable iff (rst)
    txRtsA && $stable(txRtsA) ##1 $stable(rtsReqAN) |-> outPins[0] == $past(rtsReqAN))
    else $error("transmit RTS not on channel A pin");

  a_mode_read: assert property (@(posedge ref_clk) disable iff (rst)
    setup && !pwrite && idx == IDX_MODE_A && inRange |=> prdata[7:0] == $past(rdataA))
    else $error("mode read data wrong");

  a_mode_b_read: assert property (@(posedge ref_clk) disable iff (rst)
    setup && !pwrite && idx == IDX_MODE_B && inRange |=> prdata[7:0] == $past(rdataB))
    else $error("channel B mode read data wrong");

  a_mode_zero_src: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(modeZeroA) |-> $past(accA) && $past(pwrite))
    else $error("mode zero changed without a mode write");
endmodule
`default_nettype wire

// File: bench/dumc_host.sv
// host processor model: APB master issuing single transfers
`default_nettype none
module dumc_host (
  input  wire logic        ref_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // mode zero is only reached after its pointer command
  // never both RTS control bits of one channel at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic err, output logic hung);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    hung = (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/tb_dumc_top.sv
// register-level testbench of the mode configuration block
`default_nettype none
module tb_dumc_top;
  import dumc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, rtsReqAN, irq, er, hg, tmo;
  logic        baudExt1, baudExt2, testMode, watchdogEnA, parityOddA, addrTagA, blockErrA, ctsEnA;
  logic [7:0]  paddr, r, outPins, opc, aux;
  logic [31:0] pwdata, prdata;
  logic [6:0]  evtSrc;
  logic [4:0]  txThrA, rxThrA, txThrB;
  logic [3:0]  dataBitsA;
  logic [1:0]  parityModeA, loopModeA, c;
  logic [5:0]  stopLenA;
  int          errors = 0;
  int          checked = 0;
  logic [4:0]  txT [4] = '{5'h08, 5'h04, 5'h06, 5'h01};
  logic [4:0]  rxT [4] = '{5'h01, 5'h03, 5'h06, 5'h08};
  dumc_host u_host (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  dumc_top u_dumc_top (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .inPins(7'h00),
    .evtSrc(evtSrc), .rtsReqAN(rtsReqAN), .rtsReqBN(1'b1), .outPins(outPins), .outPinConfig(opc), .auxControl(aux),
    .irq(irq), .timerOut(tmo), .baudExt1(baudExt1), .baudExt2(baudExt2), .testMode(testMode), .txThrA(txThrA),
    .rxThrA(rxThrA), .dataBitsA(dataBitsA), .parityOddA(parityOddA), .addrTagA(addrTagA),
    .parityModeA(parityModeA), .blockErrA(blockErrA), .watchdogEnA(watchdogEnA), .stopLenA(stopLenA),
    .ctsEnA(ctsEnA), .loopModeA(loopModeA), .txThrB(txThrB), .rxThrB(), .dataBitsB(), .parityOddB(),
    .addrTagB(), .parityModeB(), .blockErrB(), .watchdogEnB(), .stopLenB(), .ctsEnB(), .loopModeB());
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic ck(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // write data lands at the access edge; outputs are looked at 1 ns later
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    u_host.xfer(w, a, d, r, er, hg);
    #1;
    if (hg) begin
      errors++;
      final_report();
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  // outPins is registered, so the request shows one edge after it moves
  task automatic rtsPin();
    @(posedge ref_clk) rtsReqAN <= 1'b0;
    tick();
    ck(8'(outPins[0]), 8'h00);
    @(posedge ref_clk) rtsReqAN <= 1'b1;
    tick();
    ck(8'(outPins[0]), 8'h01);
  endtask
  initial begin
    #400000;
    errors++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    rtsReqAN = 1'b1;
    evtSrc = 7'h00;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    acc(1'b1, 8'h00, 8'h03);
    ck(8'(dataBitsA), 8'h08);
    acc(1'b1, 8'h00, 8'h4F);
    ck({loopModeA, stopLenA}, 8'h60);
    acc(1'b1, 8'h00, 8'h30);
    ck({ctsEnA, loopModeA, dataBitsA}, 8'h48);
    ck(8'(stopLenA), 8'h09);
    rtsPin();
    acc(1'b1, 8'h08, 8'hB0);
    acc(1'b1, 8'h00, 8'hFF);
    ck({baudExt1, baudExt2, testMode, watchdogEnA}, 8'h0F);
    acc(1'b1, 8'h08, 8'hB0);
    acc(1'b0, 8'h00, 8'h00);
    ck(r, 8'hF7);
    acc(1'b0, 8'h00, 8'h00);
    ck(r, 8'h03);
    acc(1'b0, 8'h00, 8'h00);
    ck(r, 8'h30);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      acc(1'b1, 8'h08, 8'hB0);
      acc(1'b1, 8'h00, {1'b0, c[1], c, 4'h0});
      acc(1'b1, 8'h00, {1'b0, c[0], c[0], c, 3'h7});
      ck(8'(txThrA), 8'(txT[i]));
      ck(8'(rxThrA), 8'(rxT[i]));
      ck({parityModeA, blockErrA, parityOddA, addrTagA}, {3'h0, c, c[0], c != 2'h3, c == 2'h3});
    end
    acc(1'b1, 8'h28, 8'hB0);
    acc(1'b1, 8'h20, 8'hFF);
    ck({baudExt1, 2'h0, txThrB}, 8'h01);
    acc(1'b1, 8'h28, 8'hB0);
    acc(1'b0, 8'h20, 8'h00);
    ck(r, 8'hF0);
    acc(1'b1, 8'h08, 8'h10);
    acc(1'b1, 8'h00, 8'h03);
    acc(1'b1, 8'h00, 8'h00);
    acc(1'b1, 8'h08, 8'h10);
    acc(1'b1, 8'h00, 8'h83);
    rtsPin();
    acc(1'b0, 8'h04, 8'h00);
    ck({er, r[6:0]}, 8'h80);
    acc(1'b1, 8'h14, 8'h01);
    @(posedge ref_clk) evtSrc <= 7'h01;
    tick();
    tick();
    ck(8'(irq), 8'h01);
    acc(1'b1, 8'h14, 8'h00);
    tick();
    ck(8'(irq), 8'h00);
    acc(1'b1, 8'h30, 8'h5A);
    acc(1'b0, 8'h30, 8'h00);
    ck(r, 8'h5A);
    acc(1'b1, 8'h34, 8'hA5);
    acc(1'b1, 8'h10, 8'h3C);
    acc(1'b0, 8'h10, 8'h00);
    ck(opc, 8'hA5);
    ck(aux, 8'h3C);
    ck({er, r[6:0]}, 8'h00);
    // pin 0 still follows the receive RTS request
    acc(1'b1, 8'h38, 8'hF0);
    acc(1'b1, 8'h3C, 8'h30);
    ck(outPins, 8'hC1);
    // preload 2: ready rises six edges after start, stop falls clear of a rise
    acc(1'b1, 8'h18, 8'h00);
    acc(1'b1, 8'h1C, 8'h02);
    acc(1'b0, 8'h38, 8'h00);
    ck(8'(tmo), 8'h01);
    repeat (8) tick();
    acc(1'b0, 8'h14, 8'h00);
    ck(r, 8'h09);
    acc(1'b0, 8'h3C, 8'h00);
    acc(1'b0, 8'h14, 8'h00);
    ck(r, 8'h01);
    final_report();
  end
endmodule
`default_nettype wire
